/* design/wse_top.sv */
// Wake status/enable registers and active-low wake output.
// Assumes i_rstn is the standby-supply power-on reset; the base address
// comes from a configuration register elsewhere; wake inputs are async.
`timescale 1ns/1ps
module wse_top (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic [15:0] i_rt_base,
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  input wire logic i_gpio_10_wake,
  input wire logic i_gpio_11_wake,
  input wire logic i_gpio_12_wake,
  input wire logic i_gpio_13_wake,
  input wire logic i_gpio_14_wake,
  input wire logic i_ring_indicate_wake,
  input wire logic i_gpio_23_wake,
  output logic [7:0] o_io_rdata,
  output logic o_wake_event_out_n
);
  import wse_pkg::*;

  typedef struct packed {
    logic [NSRC-1:0] sync1;
    logic [NSRC-1:0] sync2;
    logic gsts;
    logic gen;
    logic [7:0] sts1;
    logic [7:0] sts2;
    logic [7:0] en1;
    logic [7:0] en2;
    logic [7:0] rdata;
    logic wake_n;
  } wse_state_t;

  wse_state_t st_reg;
  wse_state_t st_next;
  logic hit;
  logic [3:0] off;
  logic [7:0] ev1;
  logic [7:0] ev2;
  logic any_next;

  assign hit = (i_rt_base >= BASE_MIN) && (i_rt_base <= BASE_MAX) &&
               (i_rt_base[3:0] == 4'h0) &&
               (i_io_addr[15:4] == i_rt_base[15:4]);
  assign off = i_io_addr[3:0];

  always_comb begin
    st_next = st_reg;
    ev1 = {3'h0, st_reg.sync2[4:0]} & MASK_GRP1;
    ev2 = RST_REG;
    ev2[BIT_RING] = st_reg.sync2[5];
    ev2[BIT_GPIO_23_WAKE] = st_reg.sync2[6];
    st_next.sync1 = {i_gpio_23_wake, i_ring_indicate_wake, i_gpio_14_wake,
                     i_gpio_13_wake, i_gpio_12_wake, i_gpio_11_wake,
                     i_gpio_10_wake};
    st_next.sync2 = st_reg.sync1;
    if (hit && i_io_wr && off == OFF_STS1) begin
      st_next.sts1 = st_reg.sts1 & ~i_io_wdata;
    end
    if (hit && i_io_wr && off == OFF_STS2) begin
      st_next.sts2 = st_reg.sts2 & ~i_io_wdata;
    end
    if (hit && i_io_wr && off == OFF_GSTS && |(i_io_wdata & MASK_GBIT)) begin
      st_next.gsts = 1'b0;
    end
    st_next.sts1 = st_next.sts1 | ev1;
    st_next.sts2 = st_next.sts2 | ev2;
    if (hit && i_io_wr && off == OFF_EN1) begin
      st_next.en1 = i_io_wdata & MASK_GRP1;
    end
    if (hit && i_io_wr && off == OFF_EN2) begin
      st_next.en2 = i_io_wdata & MASK_GRP2;
    end
    if (hit && i_io_wr && off == OFF_GEN) begin
      st_next.gen = i_io_wdata[0];
    end
    any_next = |(st_next.sts1 & st_next.en1) |
               |(st_next.sts2 & st_next.en2);
    st_next.gsts = st_next.gsts | any_next;
    st_next.wake_n = ~(any_next & st_next.gen);
    st_next.rdata = RST_REG;
    if (hit && i_io_rd) begin
      unique case (off)
        OFF_GSTS: st_next.rdata = {7'h00, st_reg.gsts};
        OFF_GEN: st_next.rdata = {7'h00, st_reg.gen};
        OFF_STS1: st_next.rdata = st_reg.sts1;
        OFF_STS2: st_next.rdata = st_reg.sts2;
        OFF_EN1: st_next.rdata = st_reg.en1;
        OFF_EN2: st_next.rdata = st_reg.en2;
        default: st_next.rdata = RST_REG;
      endcase
    end
  end

  // Only standby power-on reset clears state
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      st_reg <= '0;
      st_reg.wake_n <= 1'b1;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  assign o_io_rdata = st_reg.rdata;
  assign o_wake_event_out_n = st_reg.wake_n;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  sequence wr_sts2(logic b);
    i_ce && hit && i_io_wr && off == OFF_STS2 && i_io_wdata[0] == b;
  endsequence

  sequence sync_pass;
    i_ce ##1 i_ce;
  endsequence

  sequence rd_at(logic [3:0] o);
    i_ce && hit && i_io_rd && off == o;
  endsequence

  rsvd_read_a: assert property (
    i_ce && hit && i_io_rd && off == OFF_RSVD |=> o_io_rdata == 8'h00)
    else $error("reserved slot read nonzero");
  status_set_a: assert property (
    i_ce && st_reg.sync2[5] |=> st_reg.sts2[0])
    else $error("ring status not set");
  w1c_clear_a: assert property (
    wr_sts2(1'b1) ##0 !st_reg.sync2[5] |=> !st_reg.sts2[0])
    else $error("write one did not clear");
  w0_keep_a: assert property (
    wr_sts2(1'b0) ##0 st_reg.sts2[0] |=> st_reg.sts2[0])
    else $error("write zero changed status");
  global_off_a: assert property (
    !st_reg.gen |-> o_wake_event_out_n)
    else $error("wake asserted while disabled");
  wake_assert_a: assert property (
    st_reg.gen && |(st_reg.sts1 & st_reg.en1) |-> !o_wake_event_out_n)
    else $error("wake output missing");
  masked_src_a: assert property (
    st_reg.en1 == 8'h00 && st_reg.en2 == 8'h00 |-> o_wake_event_out_n)
    else $error("disabled source drove wake");
  gsts_set_a: assert property (
    !o_wake_event_out_n |-> st_reg.gsts)
    else $error("global status not set");
  en_write_a: assert property (
    i_ce && hit && i_io_wr && off == OFF_EN1
    |=> st_reg.en1 == ($past(i_io_wdata) & MASK_GRP1))
    else $error("enable 1 write wrong");
  decode_off_a: assert property (
    i_rt_base < BASE_MIN |=> $stable(st_reg.en1))
    else $error("decode below base range");

  ring_path_a: assert property (
    i_ce && i_ring_indicate_wake ##1 sync_pass |=> st_reg.sts2[BIT_RING])
    else $error("ring event not latched");
  gpio_23_wake_path_a: assert property (
    i_ce && i_gpio_23_wake ##1 sync_pass |=> st_reg.sts2[BIT_GPIO_23_WAKE])
    else $error("gpio 23 event not latched");
  gpio_10_wake_path_a: assert property (
    i_ce && i_gpio_10_wake ##1 sync_pass |=> st_reg.sts1[0])
    else $error("gpio 10 event not latched");
  sts2_rsvd_a: assert property (
    (st_reg.sts2 & ~MASK_GRP2) == 8'h00)
    else $error("status 2 reserved bit set");
  en1_rsvd_a: assert property (
    (st_reg.en1 & ~MASK_GRP1) == 8'h00)
    else $error("enable 1 reserved bit set");
  sts2_read_a: assert property (
    rd_at(OFF_STS2) |=> o_io_rdata == $past(st_reg.sts2))
    else $error("status 2 read wrong");
  en1_read_a: assert property (
    rd_at(OFF_EN1) |=> o_io_rdata == $past(st_reg.en1))
    else $error("enable 1 read wrong");
  sticky_sts_a: assert property (
    i_ce && st_reg.sts2[0] && !(hit && i_io_wr && off == OFF_STS2)
    |=> st_reg.sts2[0])
    else $error("status cleared without write");
  gen_write_a: assert property (
    i_ce && hit && i_io_wr && off == OFF_GEN
    |=> st_reg.gen == $past(i_io_wdata[0]))
    else $error("global enable write wrong");
  freeze_a: assert property (
    !i_ce |=> $stable(st_reg))
    else $error("state moved while frozen");
  miss_read_a: assert property (
    i_ce && !(hit && i_io_rd) |=> o_io_rdata == 8'h00)
    else $error("read data without a read");
  gsts_clear_a: assert property (
    i_ce && hit && i_io_wr && off == OFF_GSTS && i_io_wdata[0] && !any_next
    |=> !st_reg.gsts)
    else $error("global status did not clear");
endmodule : wse_top

/* design/wse_pkg.sv */
// Package for the wake event status and enable block.
// Assumes an 8-bit I/O register port behind a runtime block base.
package wse_pkg;
  localparam logic [3:0] OFF_GSTS = 4'h0;
  localparam logic [3:0] OFF_GEN = 4'h1;
  localparam logic [3:0] OFF_STS1 = 4'h2;
  localparam logic [3:0] OFF_STS2 = 4'h3;
  localparam logic [3:0] OFF_RSVD = 4'h4;
  localparam logic [3:0] OFF_EN1 = 4'h5;
  localparam logic [3:0] OFF_EN2 = 4'h6;
  localparam logic [7:0] MASK_GBIT = 8'h01;
  localparam logic [7:0] MASK_GRP1 = 8'h1f;
  localparam logic [7:0] MASK_GRP2 = 8'h21;
  localparam int BIT_RING = 0;
  localparam int BIT_GPIO_23_WAKE = 5;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [15:0] BASE_MIN = 16'h0100;
  localparam logic [15:0] BASE_MAX = 16'h0fff;
  localparam int NSRC = 7;
endpackage : wse_pkg

/* testbench/wse_wake_model.sv */
// Far-side model: drives the wake sources, watches the wake line.
// Assumes a level wake line, active low, on the bench clock.
`timescale 1ns/1ps
module wse_wake_model (
  input wire logic i_clk,
  input wire logic [6:0] i_set,
  input wire logic i_wake_n,
  output logic [6:0] o_src,
  output logic o_seen
);
  always_ff @(posedge i_clk) begin
    o_src <= i_set;
    o_seen <= !i_wake_n;
  end
endmodule : wse_wake_model

/* testbench/testbench.sv */
// Bench for the wake status and enable registers.
// Assumes wse_top and the wake model; block base 0x0200, moved to 0x0080, 0x0208 and 0x1200 in the decode test.
`timescale 1ns/1ps
module testbench;
  logic i_clk = 0, i_rstn = 0, i_io_wr = 0, i_io_rd = 0, seen, wake_n;
  logic ce = 1;
  logic [15:0] base = 16'h0200, addr = 16'h0000;
  logic [7:0] wdata = 8'h00, rdata;
  logic [6:0] set = 7'h00, src;
  int n_errors = 0, n_tests = 0;
  always #5 i_clk = ~i_clk;
  wse_top dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(ce),
    .i_rt_base(base), .i_io_addr(addr), .i_io_wr(i_io_wr),
    .i_io_rd(i_io_rd), .i_io_wdata(wdata), .i_gpio_10_wake(src[0]),
    .i_gpio_11_wake(src[1]), .i_gpio_12_wake(src[2]),
    .i_gpio_13_wake(src[3]), .i_gpio_14_wake(src[4]),
    .i_ring_indicate_wake(src[5]), .i_gpio_23_wake(src[6]),
    .o_io_rdata(rdata), .o_wake_event_out_n(wake_n));
  wse_wake_model host_u (.i_clk(i_clk), .i_set(set), .i_wake_n(wake_n),
    .o_src(src), .o_seen(seen));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [3:0] off, input logic [7:0] d);
    @(posedge i_clk);
    addr <= base + 16'(off);
    wdata <= d;
    i_io_wr <= 1'b1;
    @(posedge i_clk);
    i_io_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] off, input logic [7:0] exp);
    @(posedge i_clk);
    addr <= base + 16'(off);
    i_io_rd <= 1'b1;
    @(posedge i_clk);
    i_io_rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd
  task wake(input logic [6:0] s, input logic exp);
    @(posedge i_clk);
    set <= s;
    repeat (6) @(posedge i_clk);
    chk({7'h00, seen}, {7'h00, exp});
  endtask : wake
  task test_done;
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  initial begin
    repeat (8) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(4'h3, 8'h00);
    rd(4'h5, 8'h00);
    wr(4'h5, 8'hff);
    rd(4'h5, 8'h1f);
    wr(4'h4, 8'hff);
    rd(4'h4, 8'h00);
    $display("test registers done");
    wake(7'h60, 1'b0);
    rd(4'h3, 8'h21);
    wake(7'h00, 1'b0);
    wr(4'h3, 8'h01);
    rd(4'h3, 8'h20);
    $display("test status done");
    wake(7'h01, 1'b0);
    rd(4'h0, 8'h01);
    wr(4'h1, 8'h01);
    wake(7'h01, 1'b1);
    wake(7'h00, 1'b1);
    wr(4'h2, 8'h01);
    wake(7'h00, 1'b0);
    wake(7'h20, 1'b0);
    wr(4'h6, 8'hff);
    wake(7'h20, 1'b1);
    rd(4'h6, 8'h21);
    rd(4'h2, 8'h00);
    wake(7'h00, 1'b1);
    wr(4'h3, 8'hff);
    wake(7'h00, 1'b0);
    rd(4'h0, 8'h01);
    wr(4'h0, 8'h01);
    rd(4'h0, 8'h00);
    $display("test wake done");
    base <= 16'h0080;
    wr(4'h5, 8'h00);
    base <= 16'h0208;
    wr(4'h5, 8'h00);
    rd(4'h5, 8'h00);
    base <= 16'h1200;
    wr(4'h5, 8'h00);
    base <= 16'h0200;
    rd(4'h5, 8'h1f);
    ce <= 1'b0;
    wr(4'h5, 8'h00);
    ce <= 1'b1;
    rd(4'h5, 8'h1f);
    $display("test decode and enable done");
    wake(7'h40, 1'b1);
    wake(7'h00, 1'b1);
    rd(4'h3, 8'h20);
    @(posedge i_clk);
    i_rstn <= 1'b0;
    repeat (8) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(4'h3, 8'h00);
    rd(4'h5, 8'h00);
    rd(4'h6, 8'h00);
    rd(4'h1, 8'h00);
    wake(7'h00, 1'b0);
    $display("test reset done");
    test_done();
  end
endmodule : testbench
